// file: src/uirq_dev.sv
// Interrupt event status and enable logic of a USB host controller.
// Assumes event inputs come from logic on the same clock.
// Function
// - Raise irq when status, enable, master set
// - Status write clears ones, never sets
// - Only events set; only writes clear
// - Host uses codes 03/83 for status
// - Root hub or port change sets bit 6
// - Frame counter bit 15 toggle sets bit 5
// - System error sets bit 4, halts processing
// - Host clears error only after reset
// - Unrecoverable error bit always reads zero
// - New resume signaling sets bit 3
// - Driver-entered resume does not set bit 3
// - Frame start sets bit 2 with token, unless halted
// - Overrun sets bit 0, bumps counter
// - Enable write sets bits written one
// - Enable read returns stored enables
// - Host uses codes 04/84 for enable
// - Bit 31 is master enable, cleared by disable write
// - Enables align with status bit positions
// - Disable write clears enables written one
// - Disable read returns enable value
// - Host uses codes 05/85 for disable
// - Two-bit overrun counter wraps, always counts
`timescale 1ns/1ps
module uirq_dev (
  input  wire logic              clk,             // 20 MHz clock
  input  wire logic              nrst,            // Async reset, active low
  uirq_if.dev                    lnk,             // Command link
  input  wire logic [31:0]       root_hub_status, // Root hub status content
  input  wire logic [1:0][31:0]  downstream_port_status, // Port status content
  input  wire logic [15:0]       frame_number_counter,   // Frame counter
  input  wire logic              sys_error,       // Non-USB system error pulse
  input  wire logic              resume_signal,   // Downstream resume level
  input  wire logic              driver_resume,   // Driver-entered resume state
  input  wire logic              sof_start,       // Frame start pulse
  input  wire logic              sched_overrun,   // Schedule overrun pulse
  output logic                   sof_token,       // Start-of-frame token pulse
  output logic [1:0]             overrun_count,   // Scheduling overrun counter
  output logic                   halted           // Processing halted
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0]      status;
    logic [31:0]      enable;
    logic [31:0]      rh_prev;
    logic [1:0][31:0] port_prev;
    logic             fn_prev;
    logic             res_prev;
    logic             primed;
    logic [1:0]       soc;
    logic             halt;
    logic             ack;
    logic [31:0]      rdata;
    logic             irq;
    logic             sof;
  } uirq_dev_state_type;

  uirq_dev_state_type s_r;
  uirq_dev_state_type s_nxt;

  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] en_set;
  logic [31:0] en_clr;
  logic        take;
  logic        chg;

  // ****************************************
  // Port change detection
  // ****************************************
  // One comparator per downstream port, so a wider port set needs
  // a larger count here, on the status input and in port_prev.
  localparam int N_PORTS = 2;
  logic [N_PORTS-1:0] port_chg;

  for (genvar p = 0; p < N_PORTS; p++) begin : g_port
    assign port_chg[p] = (downstream_port_status[p] != s_r.port_prev[p]);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt  = s_r;
    set_v  = '0;
    clr_v  = '0;
    en_set = '0;
    en_clr = '0;
    take   = lnk.req && !s_r.ack;

    // ****************************************
    // Event detection
    // ****************************************
    // History registers; first cycle after reset only loads them, so a
    // nonzero input at release is not taken for a change
    s_nxt.primed    = 1'b1;
    s_nxt.rh_prev   = root_hub_status;
    s_nxt.port_prev = downstream_port_status;
    s_nxt.fn_prev   = frame_number_counter[uirq_pkg::FN_MSB];
    s_nxt.res_prev  = resume_signal;

    chg = (root_hub_status != s_r.rh_prev) || (|port_chg);
    set_v[uirq_pkg::BIT_RH_CHG] = s_r.primed && chg;
    set_v[uirq_pkg::BIT_FN_OVFL] = s_r.primed &&
        (frame_number_counter[uirq_pkg::FN_MSB] != s_r.fn_prev);
    set_v[uirq_pkg::BIT_UNRECOV] = sys_error;
    if (sys_error) begin
      s_nxt.halt = 1'b1;
    end
    set_v[uirq_pkg::BIT_RESUME] = s_r.primed && resume_signal &&
        !s_r.res_prev && !driver_resume;
    set_v[uirq_pkg::BIT_SOF] = sof_start && !s_r.halt;
    s_nxt.sof = sof_start && !s_r.halt;
    // overrun counts even if already set
    set_v[uirq_pkg::BIT_OVERRUN] = sched_overrun;
    if (sched_overrun) begin
      s_nxt.soc = s_r.soc + 2'h1;
    end

    // ****************************************
    // Link commands
    // ****************************************
    // One-cycle ack, so a held req is taken once
    s_nxt.ack   = take;
    s_nxt.rdata = '0;
    if (take) begin
      case (lnk.cmd)
        uirq_pkg::CMD_STATUS_RD: begin
          s_nxt.rdata = s_r.status & uirq_pkg::STATUS_MASK;
          s_nxt.rdata[uirq_pkg::BIT_UNRECOV] = 1'b0;
        end
        uirq_pkg::CMD_STATUS_WR: begin
          clr_v = lnk.wdata;
        end
        uirq_pkg::CMD_ENSET_RD: begin
          s_nxt.rdata = s_r.enable;
        end
        uirq_pkg::CMD_ENSET_WR: begin
          en_set = lnk.wdata;
        end
        uirq_pkg::CMD_ENCLR_RD: begin
          s_nxt.rdata = s_r.enable;
        end
        uirq_pkg::CMD_ENCLR_WR: begin
          en_clr = lnk.wdata;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    // ****************************************
    // Register update
    // ****************************************
    // Set beats clear, so an event that lands on the clearing write
    // is not lost
    // set wins over clear, reserved held at zero
    s_nxt.status = ((s_r.status & ~clr_v) | set_v) & uirq_pkg::STATUS_MASK;
    s_nxt.enable = ((s_r.enable & ~en_clr) | en_set) & uirq_pkg::ENABLE_MASK;

    s_nxt.irq = s_nxt.enable[uirq_pkg::BIT_MASTER] &&
                (|(s_nxt.status & s_nxt.enable & uirq_pkg::STATUS_MASK));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r           <= '0;
      s_r.status    <= uirq_pkg::STATUS_RESET;
      s_r.enable    <= uirq_pkg::ENABLE_RESET;
      s_r.soc       <= uirq_pkg::SOC_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Halt is left only by reset; the driver is expected to clear the
  // error flag after that reset.
  assign lnk.ack       = s_r.ack;
  assign lnk.rdata     = s_r.rdata;
  assign lnk.irq       = s_r.irq;
  assign sof_token     = s_r.sof;
  assign overrun_count = s_r.soc;
  assign halted        = s_r.halt;
endmodule

// file: common/uirq_pkg.sv
// Shared constants for the interrupt event logic and its host-side controller.
// Assumes both ends run on one clock and meet through uirq_if.
package uirq_pkg;
  // ****************************************
  // Link command codes
  // ****************************************
  localparam logic [7:0] CMD_STATUS_RD = 8'h03;
  localparam logic [7:0] CMD_STATUS_WR = 8'h83;
  localparam logic [7:0] CMD_ENSET_RD  = 8'h04;
  localparam logic [7:0] CMD_ENSET_WR  = 8'h84;
  localparam logic [7:0] CMD_ENCLR_RD  = 8'h05;
  localparam logic [7:0] CMD_ENCLR_WR  = 8'h85;

  // ****************************************
  // Event bit positions
  // ****************************************
  localparam int BIT_OVERRUN  = 0;
  localparam int BIT_SOF      = 2;
  localparam int BIT_RESUME   = 3;
  localparam int BIT_UNRECOV  = 4;
  localparam int BIT_FN_OVFL  = 5;
  localparam int BIT_RH_CHG   = 6;
  localparam int BIT_MASTER   = 31;
  localparam int FN_MSB       = 15;

  localparam logic [31:0] STATUS_MASK  = 32'h0000_007d;
  localparam logic [31:0] ENABLE_MASK  = 32'h8000_007d;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [1:0]  SOC_RESET    = 2'h0;

  // ****************************************
  // Controller register offsets (Avalon byte addresses)
  // ****************************************
  localparam logic [3:0] OFS_CMD   = 4'h0;
  localparam logic [3:0] OFS_WDATA = 4'h4;
  localparam logic [3:0] OFS_RDATA = 4'h8;
  localparam logic [3:0] OFS_STAT  = 4'hc;
  localparam int STAT_BUSY = 0;
  localparam int STAT_IRQ  = 1;
endpackage

// file: common/uirq_if.sv
// Link between the host-side controller and the interrupt event logic.
// Assumes one shared clock; no tristate pins.
`timescale 1ns/1ps
interface uirq_if;
  logic        req;    // Host holds a command until ack
  logic [7:0]  cmd;    // Command code
  logic [31:0] wdata;  // Write data
  logic        ack;    // One-cycle answer
  logic [31:0] rdata;  // Read data, valid with ack
  logic        irq;    // Interrupt request level

  modport dev  (input req, cmd, wdata, output ack, rdata, irq);
  modport host (output req, cmd, wdata, input ack, rdata, irq);
endinterface

// file: src/uirq_host.sv
// Host-side controller: takes orders over Avalon-MM, issues link commands.
// Assumes the device answers each command with a one-cycle ack.
`timescale 1ns/1ps
module uirq_host (
  input  wire logic        clk,                 // 20 MHz clock
  input  wire logic        nrst,                // Async reset, active low
  uirq_if.host             lnk,                 // Command link
  input  wire logic [3:0]  avs_address,         // Byte address
  input  wire logic        avs_read,            // Read strobe
  input  wire logic        avs_write,           // Write strobe
  input  wire logic [31:0] avs_writedata,       // Write data
  output logic [31:0]      avs_readdata,        // Read data
  output logic             avs_waitrequest,     // Stall
  output logic             irq_out              // Device irq, passed on
);

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_BUSY = 1'b1
  } uirq_host_phase_type;

  typedef struct packed {
    uirq_host_phase_type ph;
    logic             req;
    logic [7:0]       cmd;
    logic [31:0]      wdata;
    logic [31:0]      rdata;
    logic [31:0]      rd_out;
    logic             rd_done;
  } uirq_host_state_type;

  uirq_host_state_type s_r;
  uirq_host_state_type s_nxt;
  logic                cmd_wr;

  // ****************************************
  // Bus and link control
  // ****************************************
  // A command write while busy stalls so orders are never dropped.
  assign cmd_wr = avs_write && (avs_address == uirq_pkg::OFS_CMD);
  assign avs_waitrequest = (avs_read && !s_r.rd_done) ||
                           (cmd_wr && (s_r.ph == PH_BUSY));

  always_comb begin
    s_nxt         = s_r;
    s_nxt.rd_done = avs_read && !s_r.rd_done;
    if (avs_read && !s_r.rd_done) begin
      case (avs_address)
        uirq_pkg::OFS_CMD:   s_nxt.rd_out = {24'h0, s_r.cmd};
        uirq_pkg::OFS_WDATA: s_nxt.rd_out = s_r.wdata;
        uirq_pkg::OFS_RDATA: s_nxt.rd_out = s_r.rdata;
        uirq_pkg::OFS_STAT: begin
          s_nxt.rd_out = '0;
          s_nxt.rd_out[uirq_pkg::STAT_BUSY] = (s_r.ph == PH_BUSY);
          s_nxt.rd_out[uirq_pkg::STAT_IRQ]  = lnk.irq;
        end
        default:             s_nxt.rd_out = '0;
      endcase
    end
    if (avs_write && (avs_address == uirq_pkg::OFS_WDATA)) begin
      s_nxt.wdata = avs_writedata;
    end
    case (s_r.ph)
      PH_IDLE: begin
        if (cmd_wr) begin
          s_nxt.cmd = avs_writedata[7:0];
          s_nxt.req = 1'b1;
          s_nxt.ph  = PH_BUSY;
        end
      end
      PH_BUSY: begin
        if (lnk.ack) begin
          s_nxt.req   = 1'b0;
          s_nxt.rdata = lnk.rdata;
          s_nxt.ph    = PH_IDLE;
        end
      end
      default: begin
        s_nxt.ph = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r    <= '0;
      s_r.ph <= PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.req      = s_r.req;
  assign lnk.cmd      = s_r.cmd;
  assign lnk.wdata    = s_r.wdata;
  assign avs_readdata = s_r.rd_out;
  assign irq_out      = lnk.irq;
endmodule

// file: tb/uirq_properties.sv
// Link checker for the interrupt event logic.
// Assumes the bench wires it to the link signals.
`timescale 1ns/1ps
module uirq_properties (
  input wire logic        clk,   // Clock
  input wire logic        nrst,  // Reset, active low
  input wire logic        req,   // Request
  input wire logic [7:0]  cmd,   // Code
  input wire logic [31:0] wdata, // Write data
  input wire logic        ack,   // Answer
  input wire logic [31:0] rdata, // Read data
  input wire logic        irq    // Interrupt
);
  // ****
  // Enable shadow and checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [31:0] en_r;
  wire         tk = req && !ack;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      en_r <= 32'h0;
    else if (tk && cmd == 8'h84)
      en_r <= en_r | (wdata & uirq_pkg::ENABLE_MASK);
    else if (tk && cmd == 8'h85)
      en_r <= en_r & ~wdata;
  end
  property p_ack_next; tk |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_idle; !ack |-> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_stat; ack && $past(cmd) == 8'h03 |-> (rdata & ~32'h6d) == 32'h0; endproperty
  a_stat: assert property (p_stat) else $error("status bits");
  property p_en; ack && $past(cmd) inside {8'h04, 8'h05} |-> rdata == en_r; endproperty
  a_en: assert property (p_en) else $error("enable read");
  property p_irq; irq |-> en_r[31] && (|en_r[6:0]); endproperty
  a_irq: assert property (p_irq) else $error("irq cause");
  property p_hold; tk |=> req && $stable(cmd) && $stable(wdata); endproperty
  a_hold: assert property (p_hold) else $error("req moved");
  property p_drop; ack |=> !req; endproperty
  a_drop: assert property (p_drop) else $error("req kept");
endmodule

// file: tb/usb_host_irq_status_enable_bench.sv
// Bench: host controller driving the interrupt event logic.
// Assumes both ends, link and checker compile beside it.
`timescale 1ns/1ps
module usb_host_irq_status_enable_bench;
  // ****
  // Wiring
  // ****
  logic             clk = 0, nrst = 0, rd = 0, wr = 0;
  logic             rsm = 0, drs = 0, sof = 0, ovr = 0, sye = 0;
  logic [3:0]       adr = 0;
  logic [31:0]      wd = 0, rh = 0, q, en, d, rdd;
  logic [1:0][31:0] dp = 0;
  logic [15:0]      fn = 0;
  logic [7:0]       c;
  logic             wt, irqo, tok, hlt, tks;
  logic [1:0]       oc;
  int               bad_count = 0, n_compared = 0;
  int               pos[7] = '{6, 6, 5, 3, 2, 0, 4};
  uirq_if lnk();
  uirq_dev uirq_dev_i (.clk, .nrst, .lnk, .root_hub_status(rh), .downstream_port_status(dp),
    .frame_number_counter(fn), .sys_error(sye), .resume_signal(rsm), .driver_resume(drs),
    .sof_start(sof), .sched_overrun(ovr), .sof_token(tok), .overrun_count(oc), .halted(hlt));
  uirq_host uirq_host_i (.clk, .nrst, .lnk, .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdd), .avs_waitrequest(wt), .irq_out(irqo));
  uirq_properties uirq_properties_i (.clk, .nrst, .req(lnk.req), .cmd(lnk.cmd),
    .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata), .irq(lnk.irq));
  always #25 clk = ~clk;
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Readable status flag raised by event k; the error flag always reads zero
  function automatic logic [31:0] exp_flag(input int k);
    return (k == 6) ? 32'h0 : (32'h1 << pos[k]);
  endfunction
  // Request stands from a rising edge up to the edge that sees waitrequest
  // low; read data are taken at that edge, then released one edge apart
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    adr <= a;
    wd <= v;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    q = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Only the watchdog ends a command that never completes
  task automatic op(input logic [7:0] k, input logic [31:0] v);
    bus(1'b1, uirq_pkg::OFS_WDATA, v);
    bus(1'b1, uirq_pkg::OFS_CMD, {24'h0, k});
    do begin
      bus(1'b0, uirq_pkg::OFS_STAT, 32'h0);
    end while (q[uirq_pkg::STAT_BUSY] !== 1'b0);
    bus(1'b0, uirq_pkg::OFS_RDATA, 32'h0);
  endtask
  task automatic ev(input int k);
    case (k)
      0: rh <= rh ^ ($urandom | 32'h1);
      1: dp[1] <= dp[1] ^ ($urandom | 32'h1);
      2: fn <= {~fn[15], 15'($urandom)};
      3: rsm <= 1;
      4: sof <= 1;
      5: ovr <= 1;
      default: sye <= 1;
    endcase
    @(posedge clk);
    {rsm, sof, ovr, sye} <= 4'h0;
    @(posedge clk);
    // Token pulse stands in the cycle after the event edge
    tks = tok;
    @(posedge clk);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(89903));
    repeat (20) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    op(8'h03, 0);
    chk(q, 32'h0);
    op(8'h04, 0);
    chk(q, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    en = 0;
    for (int i = 0; i < 30; i++) begin
      d = i < 2 ? '1 : $urandom;
      c = i == 1 || $urandom_range(1) ? 8'h85 : 8'h84;
      op(c, d);
      en = c[0] ? en & ~d : en | (d & uirq_pkg::ENABLE_MASK);
      op(8'h04, 0);
      chk(q, en);
      op(8'h05, 0);
      chk(q, en);
    end
    // Unknown code: answered with zero and no effect
    op(8'h07, '1);
    chk(q, 32'h0);
    op(8'h04, 0);
    chk(q, en);
    op(8'h84, '1);
    for (int k = 0; k < 6; k++) begin
      d = exp_flag(k);
      ev(k);
      chk({31'h0, tks}, {31'h0, k == 4});
      op(8'h03, 0);
      chk(q, d);
      bus(1'b0, uirq_pkg::OFS_STAT, 32'h0);
      chk({31'h0, q[1]}, 32'h1);
      op(8'h85, 32'h8000_0000);
      chk({31'h0, irqo}, 32'h0);
      op(8'h84, 32'h8000_0000);
      chk({31'h0, irqo}, 32'h1);
      op(8'h83, ~d);
      op(8'h03, 0);
      chk(q, d);
      op(8'h83, d);
      bus(1'b0, uirq_pkg::OFS_STAT, 32'h0);
      chk({31'h0, q[1]}, 32'h0);
      chk({31'h0, irqo}, 32'h0);
    end
    chk({30'h0, oc}, 32'h1);
    ovr <= 1'b1;
    repeat (3) @(posedge clk);
    ovr <= 1'b0;
    @(posedge clk);
    chk({30'h0, oc}, 32'h0);
    op(8'h83, '1);
    // Error: hidden flag still raises irq, frame token stops
    ev(6);
    op(8'h03, 0);
    chk(q, exp_flag(6));
    chk({31'h0, irqo}, 32'h1);
    chk({31'h0, hlt}, 32'h1);
    ev(4);
    chk({31'h0, tks}, 32'h0);
    op(8'h03, 0);
    chk(q, 32'h0);
    // Mid-run reset, then the error flag is cleared
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({31'h0, hlt}, 32'h0);
    op(8'h83, 32'h0000_0010);
    op(8'h04, 0);
    chk(q, 32'h0);
    chk({31'h0, irqo}, 32'h0);
    op(8'h83, '1);
    drs <= 1'b1;
    ev(3);
    op(8'h03, 0);
    chk(q, 32'h0);
    end_sim;
  end
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
endmodule
